//--- shared/mrs_pkg.sv
// Package for the receive statistics counter bank: constants, indices and carriers
// Functional notes
// - All counters are zero 38 clocks after reset falls.
// - With wide interface enabled, writes subtract, saturating at zero.
// - With wide interface disabled, writes store the value directly.
// - Interrupt pending whenever enabled and any counter is at or above half range.
// - Interrupt drops once no counter remains at or above half range.
// - Counters are 32 bits and wrap from all ones to zero.
// - Good count: accepted, 64 to max length, no CRC, alignment or code error.
// - Broadcast count: good frames to the all-ones address only.
// - Multicast count: good frames to multicast addresses other than broadcast.
// - Pause count: matching type and opcode, good, in range, flow control enabled.
// - CRC error: accepted, in range, even nibbles, bad check, no other error.
// - Alignment error: odd nibbles, check fails ignoring final nibble.
// - Code error: receive error input high during reception; counted with alignment.
// - Oversize count: accepted, longer than max, error free.
// - Long errored count: accepted, longer than max, with an error.
// - Undersize count: accepted data frame below 64 bytes, error free.
// - Fragment count: data frame below 64 bytes with error, excluding flow collisions.
// - Filtered count: error free data frame rejected by the address filter.
// - QOS count: accepted good frame, QOS on, threshold at least free buffers.
// - Byte count: add length of each good frame.
// - Receive overruns never affect any of these counts.
package mrs_pkg;

  localparam int unsigned NUM_CNT        = 13;
  localparam int unsigned IDX_W          = 4;
  localparam int unsigned CLR_CYCLES     = 38;
  localparam logic [5:0]  CLR_LAST       = 6'h25;
  localparam logic [15:0] MIN_FRAME_LEN  = 16'h0040;
  localparam logic [15:0] PAUSE_TYPE     = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE   = 16'h0001;
  localparam logic [47:0] BCAST_ADDR     = 48'hFFFF_FFFF_FFFF;
  localparam int unsigned GROUP_BIT      = 40;
  localparam int unsigned HALF_RANGE_BIT = 31;
  localparam logic [31:0] CNT_RESET      = 32'h0000_0000;

  // Register indices in the statistics space
  localparam logic [IDX_W-1:0] IDX_GOOD      = 4'h0;
  localparam logic [IDX_W-1:0] IDX_BCAST     = 4'h1;
  localparam logic [IDX_W-1:0] IDX_MCAST     = 4'h2;
  localparam logic [IDX_W-1:0] IDX_PAUSE     = 4'h3;
  localparam logic [IDX_W-1:0] IDX_CRC       = 4'h4;
  localparam logic [IDX_W-1:0] IDX_ALIGN     = 4'h5;
  localparam logic [IDX_W-1:0] IDX_OVERSIZE  = 4'h6;
  localparam logic [IDX_W-1:0] IDX_LONG_ERR  = 4'h7;
  localparam logic [IDX_W-1:0] IDX_UNDERSIZE = 4'h8;
  localparam logic [IDX_W-1:0] IDX_FRAGMENT  = 4'h9;
  localparam logic [IDX_W-1:0] IDX_FILTERED  = 4'hA;
  localparam logic [IDX_W-1:0] IDX_QOS       = 4'hB;
  localparam logic [IDX_W-1:0] IDX_BYTES     = 4'hC;

  // End-of-frame summary from the receive path, valid for one cycle
  typedef struct packed {
    logic        done;
    logic        accepted;
    logic        is_control;
    logic [47:0] dest_addr;
    logic [15:0] length;
    logic        odd_nibbles;
    logic        fcs_fail;
    logic        fcs_fail_trunc;
    logic [15:0] len_type;
    logic [15:0] opcode;
    logic        flow_collision;
    logic [15:0] chan_threshold;
    logic [15:0] chan_free;
  } mrs_frame_t;

  // Host access port
  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [IDX_W-1:0] idx;
    logic [31:0]      wdata;
  } mrs_host_req_t;

endpackage : mrs_pkg

//--- hw/mrs_rx_stats.sv
// Receive statistics counter bank with host read, write and decrement access
`timescale 1ns/1ps
`default_nettype none
module mrs_rx_stats
  import mrs_pkg::*;
(
  input  wire logic          clk_sys_in,
  input  wire logic          sys_rst_in,
  input  wire mrs_host_req_t host_req_in,
  input  wire mrs_frame_t    frame_in,
  input  wire logic          rx_frame_active_in,
  input  wire logic          rx_error_input_in,
  input  wire logic          wide_interface_enable_in,
  input  wire logic          tx_flow_ctrl_enable_in,
  input  wire logic          rx_qos_enable_in,
  input  wire logic          stats_irq_enable_in,
  input  wire logic [15:0]   rx_max_frame_length_in,
  output logic [31:0]        host_rdata_out,
  output logic               host_rvalid_out,
  output logic               stats_ready_out,
  output logic               stats_irq_pending_out
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] sat_sub(input logic [31:0] a, input logic [31:0] b);
    sat_sub = (b > a) ? CNT_RESET : a - b;
  endfunction : sat_sub

  function automatic logic [31:0] bump(input logic hit);
    bump = hit ? 32'h0000_0001 : 32'h0000_0000;
  endfunction : bump

  ////////////////////////////////////////////////////////////////////////
  // State

  logic [31:0] cnt_q [NUM_CNT];
  logic [31:0] cnt_d [NUM_CNT];
  logic [31:0] inc   [NUM_CNT];
  logic [5:0]  clr_cnt_q;
  logic        clr_busy_q;
  logic        ready_q;
  logic        rxer_meta_q;
  logic        rxer_sync_q;
  logic        code_err_q;
  logic [31:0] rdata_q;
  logic        rvalid_q;
  logic        irq_q;

  ////////////////////////////////////////////////////////////////////////
  // Post-reset clear sequence

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      clr_cnt_q  <= 6'h00;
      clr_busy_q <= 1'b1;
      ready_q    <= 1'b0;
    end else if (clr_busy_q) begin
      clr_cnt_q <= clr_cnt_q + 6'h01;
      if (clr_cnt_q == CLR_LAST) begin
        clr_busy_q <= 1'b0;
        ready_q    <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Code error capture from the receive error pin

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rxer_meta_q <= 1'b0;
      rxer_sync_q <= 1'b0;
    end else begin
      rxer_meta_q <= rx_error_input_in;
      rxer_sync_q <= rxer_meta_q;
    end
  end

  // Sticky for the frame; set wins over the end-of-frame clear
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      code_err_q <= 1'b0;
    end else if (rx_frame_active_in && rxer_sync_q) begin
      code_err_q <= 1'b1;
    end else if (frame_in.done) begin
      code_err_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame classification

  logic code_err;
  logic crc_err;
  logic align_err;
  logic any_err;
  logic in_range;
  logic too_long;
  logic too_short;
  logic is_bcast;
  logic is_mcast;
  logic good;
  logic is_data;

  always_comb begin
    code_err  = code_err_q || (rx_frame_active_in && rxer_sync_q);
    align_err = frame_in.odd_nibbles && frame_in.fcs_fail_trunc;
    crc_err   = !frame_in.odd_nibbles && frame_in.fcs_fail
                && !align_err && !code_err;
    any_err   = crc_err || align_err || code_err;
    too_long  = frame_in.length > rx_max_frame_length_in;
    too_short = frame_in.length < MIN_FRAME_LEN;
    in_range  = !too_long && !too_short;
    is_bcast  = frame_in.dest_addr == BCAST_ADDR;
    is_mcast  = frame_in.dest_addr[GROUP_BIT] && !is_bcast;
    is_data   = !frame_in.is_control;
    good      = frame_in.done && frame_in.accepted && in_range && !any_err;
  end

  // Per-counter increments; overrun is not an input here
  always_comb begin
    for (int i = 0; i < NUM_CNT; i++) begin
      inc[i] = 32'h0000_0000;
    end
    inc[IDX_GOOD]      = bump(good);
    inc[IDX_BCAST]     = bump(good && is_bcast);
    inc[IDX_MCAST]     = bump(good && is_mcast);
    inc[IDX_PAUSE]     = bump(good && tx_flow_ctrl_enable_in
                              && frame_in.len_type == PAUSE_TYPE
                              && frame_in.opcode == PAUSE_OPCODE);
    inc[IDX_CRC]       = bump(frame_in.done && frame_in.accepted && in_range
                              && crc_err);
    inc[IDX_ALIGN]     = bump(frame_in.done && frame_in.accepted && in_range
                              && (align_err || code_err));
    inc[IDX_OVERSIZE]  = bump(frame_in.done && frame_in.accepted && too_long
                              && !any_err);
    inc[IDX_LONG_ERR]  = bump(frame_in.done && frame_in.accepted && too_long
                              && any_err);
    inc[IDX_UNDERSIZE] = bump(frame_in.done && frame_in.accepted && is_data
                              && too_short && !any_err);
    inc[IDX_FRAGMENT]  = bump(frame_in.done && is_data && too_short && any_err
                              && !frame_in.flow_collision);
    inc[IDX_FILTERED]  = bump(frame_in.done && !frame_in.accepted && is_data
                              && !any_err);
    inc[IDX_QOS]       = bump(good && rx_qos_enable_in
                              && frame_in.chan_threshold >= frame_in.chan_free);
    inc[IDX_BYTES]     = good ? {16'h0000, frame_in.length} : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter update: host write result plus event increment

  logic [31:0] base;

  always_comb begin
    base = 32'h0000_0000;
    for (int i = 0; i < NUM_CNT; i++) begin
      base = cnt_q[i];
      // Full-word writes only; no byte lanes exist
      if (host_req_in.wr && host_req_in.idx == IDX_W'(i)) begin
        if (wide_interface_enable_in) begin
          base = sat_sub(cnt_q[i], host_req_in.wdata);
        end else begin
          base = host_req_in.wdata;
        end
      end
      // Wraps naturally at 32 bits
      cnt_d[i] = base + inc[i];
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        cnt_q[i] <= CNT_RESET;
      end
    end else if (clr_busy_q) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        cnt_q[i] <= CNT_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CNT; i++) begin
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host read path

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= host_req_in.rd;
      if (host_req_in.rd) begin
        rdata_q <= (host_req_in.idx < IDX_W'(NUM_CNT)) ?
                   cnt_q[host_req_in.idx] : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Half-range interrupt

  logic any_half;

  always_comb begin
    any_half = 1'b0;
    for (int i = 0; i < NUM_CNT; i++) begin
      any_half = any_half | cnt_q[i][HALF_RANGE_BIT];
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= stats_irq_enable_in && any_half;
    end
  end

  assign host_rdata_out        = rdata_q;
  assign host_rvalid_out       = rvalid_q;
  assign stats_ready_out       = ready_q;
  assign stats_irq_pending_out = irq_q;

endmodule : mrs_rx_stats
`default_nettype wire

//--- sim/mrs_rx_stats_checker.sv
// Assertion checker for the receive statistics counter bank
`timescale 1ns/1ps
`default_nettype none
module mrs_rx_stats_checker
  import mrs_pkg::*;
(
  input wire logic          clk_sys_in,
  input wire logic          sys_rst_in,
  input wire mrs_host_req_t host_req_in,
  input wire mrs_frame_t    frame_in,
  input wire logic          wide_interface_enable_in,
  input wire logic          stats_irq_enable_in,
  input wire logic [31:0]   host_rdata_out,
  input wire logic          host_rvalid_out,
  input wire logic          stats_ready_out,
  input wire logic          stats_irq_pending_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic [5:0] clr_cnt_q;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      clr_cnt_q <= 6'h00;
    end else if (clr_cnt_q != 6'h3F) begin
      clr_cnt_q <= clr_cnt_q + 6'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence wr_s(logic wide);
    host_req_in.wr && host_req_in.idx < 4'hD && stats_ready_out && !frame_in.done
      && wide_interface_enable_in == wide;
  endsequence
  sequence rd_back_s;
    host_req_in.rd && host_req_in.idx == $past(host_req_in.idx);
  endsequence
  ready_late_a: assert property (clr_cnt_q == 6'h26 |-> stats_ready_out)
    else $error("ready not raised at end of clear");
  ready_early_a: assert property (clr_cnt_q < 6'h26 |-> !stats_ready_out)
    else $error("ready raised before end of clear");
  ready_hold_a: assert property (stats_ready_out |=> stats_ready_out)
    else $error("ready dropped without reset");
  rvalid_pulse_a: assert property (host_req_in.rd && stats_ready_out |=> host_rvalid_out)
    else $error("read not answered next cycle");
  rvalid_only_a: assert property (!host_req_in.rd |=> !host_rvalid_out)
    else $error("read valid without a read");
  bad_idx_a: assert property (host_req_in.rd && host_req_in.idx > 4'hC && stats_ready_out
    |=> host_rdata_out == 32'h0000_0000) else $error("unmapped read not zero");
  write_direct_a: assert property (wr_s(1'b0) ##1 rd_back_s
    |=> host_rdata_out == $past(host_req_in.wdata, 2)) else $error("direct write lost");
  write_clear_a: assert property (
    wr_s(1'b1) ##0 host_req_in.wdata == 32'hFFFF_FFFF ##1 rd_back_s
    |=> host_rdata_out == 32'h0000_0000) else $error("decrement by all ones not zero");
  irq_mask_a: assert property (!stats_irq_enable_in |=> !stats_irq_pending_out)
    else $error("interrupt pending while disabled");
  irq_seen_a: assert property (
    host_req_in.rd && host_req_in.idx < 4'hD && stats_irq_enable_in && stats_ready_out
    |=> !host_rdata_out[31] || stats_irq_pending_out) else $error("half range not flagged");
endmodule : mrs_rx_stats_checker
bind mrs_rx_stats mrs_rx_stats_checker u_chk (.clk_sys_in, .sys_rst_in, .host_req_in,
  .frame_in, .wide_interface_enable_in, .stats_irq_enable_in, .host_rdata_out,
  .host_rvalid_out, .stats_ready_out, .stats_irq_pending_out);
`default_nettype wire

//--- sim/tb_mrs_rx_stats.sv
// Self-checking bench for the receive statistics counter bank
`timescale 1ns/1ps
`default_nettype none
module tb_mrs_rx_stats
  import mrs_pkg::*;
;
  logic          clk_sys_in = 1'b0, sys_rst_in = 1'b1;
  logic          rx_frame_active_in = 1'b0, rx_error_input_in = 1'b0;
  logic          wide_interface_enable_in = 1'b0, tx_flow_ctrl_enable_in = 1'b1;
  logic          rx_qos_enable_in = 1'b1, stats_irq_enable_in = 1'b0;
  logic [15:0]   rx_max_frame_length_in = 16'h05EE;
  mrs_host_req_t host_req_in = '0;
  mrs_frame_t    frame_in = '0;
  logic [31:0]   host_rdata_out, model_cnt [NUM_CNT];
  logic          host_rvalid_out, stats_ready_out, stats_irq_pending_out;
  int            error_cnt = 0, samples_checked = 0;
  mrs_rx_stats uut (.clk_sys_in, .sys_rst_in, .host_req_in, .frame_in, .rx_frame_active_in,
    .rx_error_input_in, .wide_interface_enable_in, .tx_flow_ctrl_enable_in, .rx_qos_enable_in,
    .stats_irq_enable_in, .rx_max_frame_length_in, .host_rdata_out, .host_rvalid_out,
    .stats_ready_out, .stats_irq_pending_out);
  initial begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge clk_sys_in);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  function automatic void inc(input int idx, input logic hit, input logic [31:0] amt);
    if (hit) model_cnt[idx] += amt;
  endfunction : inc
  function automatic void apply_wr();
    logic [31:0] c;
    if (host_req_in.idx < NUM_CNT) begin
      c = model_cnt[host_req_in.idx];
      model_cnt[host_req_in.idx] = !wide_interface_enable_in ? host_req_in.wdata :
        (host_req_in.wdata > c ? 32'h0000_0000 : c - host_req_in.wdata);
    end
  endfunction : apply_wr
  function automatic void bump(input mrs_frame_t f, input logic code);
    logic err, inr, big, good, sml;
    err = (!f.odd_nibbles && f.fcs_fail) || (f.odd_nibbles && f.fcs_fail_trunc) || code;
    inr = f.length >= MIN_FRAME_LEN && f.length <= rx_max_frame_length_in;
    big = f.length > rx_max_frame_length_in;
    sml = f.length < MIN_FRAME_LEN && !f.is_control;
    good = f.accepted && inr && !err;
    inc(IDX_GOOD, good, 1);
    inc(IDX_BCAST, good && f.dest_addr == BCAST_ADDR, 1);
    inc(IDX_MCAST, good && f.dest_addr[GROUP_BIT] && f.dest_addr != BCAST_ADDR, 1);
    inc(IDX_PAUSE, good && f.len_type == PAUSE_TYPE && f.opcode == PAUSE_OPCODE
      && tx_flow_ctrl_enable_in, 1);
    inc(IDX_CRC, f.accepted && inr && !f.odd_nibbles && f.fcs_fail && !code, 1);
    inc(IDX_ALIGN, f.accepted && inr && ((f.odd_nibbles && f.fcs_fail_trunc) || code),
      1);
    inc(IDX_OVERSIZE, f.accepted && big && !err, 1);
    inc(IDX_LONG_ERR, f.accepted && big && err, 1);
    inc(IDX_UNDERSIZE, f.accepted && sml && !err, 1);
    inc(IDX_FRAGMENT, sml && err && !f.flow_collision, 1);
    inc(IDX_FILTERED, !f.accepted && !f.is_control && !err, 1);
    inc(IDX_QOS, good && rx_qos_enable_in && f.chan_threshold >= f.chan_free, 1);
    inc(IDX_BYTES, good, 32'(f.length));
  endfunction : bump
  task automatic host_wr(input logic [3:0] idx, input logic [31:0] val);
    host_req_in.idx = idx;
    host_req_in.wdata = val;
    host_req_in.wr = 1'b1;
    apply_wr();
    tick();
    host_req_in.wr = 1'b0;
  endtask : host_wr
  task automatic send(input mrs_frame_t f, input logic code, input logic wr);
    rx_frame_active_in = 1'b1;
    rx_error_input_in = code;
    tick();
    rx_error_input_in = 1'b0;
    repeat (4) tick();
    frame_in = f;
    host_req_in.wr = wr;
    if (wr) apply_wr();
    bump(f, code);
    tick();
    frame_in.done = 1'b0;
    host_req_in.wr = 1'b0;
    rx_frame_active_in = 1'b0;
  endtask : send
  task automatic check_all();
    logic any;
    any = 1'b0;
    host_req_in.rd = 1'b1;
    for (int i = 0; i < 14; i++) begin
      host_req_in.idx = 4'(i);
      tick();
      check("rvalid", {31'h0, host_rvalid_out}, 32'h0000_0001);
      check("count", host_rdata_out, i < 13 ? model_cnt[i] : 32'h0);
      if (i < 13) any |= model_cnt[i][31];
    end
    host_req_in.rd = 1'b0;
    tick();
    check("irq", {31'h0, stats_irq_pending_out}, {31'h0, any & stats_irq_enable_in});
  endtask : check_all
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mrs_frame_t f;
    void'($urandom(62608));
    foreach (model_cnt[i]) model_cnt[i] = 32'h0000_0000;
    repeat (6) @(posedge clk_sys_in);
    #1 sys_rst_in = 1'b0;
    for (int w = 0; w < 60 && !stats_ready_out; w++) tick();
    check("ready", {31'h0, stats_ready_out}, 32'h0000_0001);
    check_all();
    stats_irq_enable_in = 1'b1;
    host_wr(IDX_GOOD, 32'hFFFF_FFFF);
    check_all();
    f = '0;
    {f.done, f.accepted, f.length} = {2'b11, MIN_FRAME_LEN};
    send(f, 1'b0, 1'b0);
    check_all();
    host_wr(IDX_GOOD, 32'h8000_0000);
    check_all();
    stats_irq_enable_in = 1'b0;
    check_all();
    {stats_irq_enable_in, wide_interface_enable_in} = 2'b11;
    host_wr(IDX_GOOD, 32'hFFFF_FFFF);
    check_all();
    for (int n = 0; n < 400; n++) begin
      if (n % 50 == 0) begin
        {wide_interface_enable_in, tx_flow_ctrl_enable_in, rx_qos_enable_in,
          stats_irq_enable_in} = 4'($urandom);
        rx_max_frame_length_in = 16'(64 + $urandom % 1500);
      end
      {f.accepted, f.is_control, f.odd_nibbles, f.fcs_fail, f.fcs_fail_trunc,
        f.flow_collision} = 6'($urandom);
      f.dest_addr = $urandom % 3 == 0 ? BCAST_ADDR : {16'($urandom), 32'($urandom)};
      f.length = 16'($urandom % 2000);
      if ($urandom % 2) f.length = $urandom % 2 ? MIN_FRAME_LEN - 16'($urandom % 2) :
        rx_max_frame_length_in + 16'($urandom % 2);
      {f.len_type, f.opcode} = $urandom % 2 ? {PAUSE_TYPE, PAUSE_OPCODE} : 32'($urandom);
      if (f.len_type == PAUSE_TYPE && f.opcode == PAUSE_OPCODE) f.accepted = 1'b1;
      {f.chan_threshold, f.chan_free} = {16'($urandom % 4), 16'($urandom % 4)};
      host_req_in.idx = 4'($urandom);
      host_req_in.wdata = $urandom % 2 ? $urandom : 32'hFFFF_FFFF;
      send(f, $urandom % 4 == 0, $urandom % 4 == 0);
      if (n % 50 == 49) check_all();
    end
    // Mid-run reset: counts cleared, writes refused until clear ends
    sys_rst_in = 1'b1;
    foreach (model_cnt[i]) model_cnt[i] = 32'h0000_0000;
    repeat (2) tick();
    sys_rst_in = 1'b0;
    host_req_in.idx = IDX_GOOD;
    host_req_in.wdata = 32'h0000_1234;
    host_req_in.wr = 1'b1;
    tick();
    host_req_in.wr = 1'b0;
    repeat (36) tick();
    check("ready", {31'h0, stats_ready_out}, 32'h0000_0000);
    tick();
    check("ready", {31'h0, stats_ready_out}, 32'h0000_0001);
    check_all();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    error_cnt++;
    give_verdict();
  end
endmodule : tb_mrs_rx_stats
`default_nettype wire
